// ---- hw/cfp_params.svh ----
// address and field constants for the fetch pipeline core
`ifndef CFP_PARAMS_SVH
`define CFP_PARAMS_SVH
`define CFP_PC_WIDTH 21
`define CFP_PC_STEP 21'h000002
`define CFP_PC_RESET 21'h000000
`define CFP_DADDR_WIDTH 12
`define CFP_DMEM_BYTES 4096
`define CFP_GPR_BYTES 256
`define CFP_SFR_BASE 12'hf80
`define CFP_SFR_TOP 12'hfff
`define CFP_ACCESS_SPLIT 8'h80
`define CFP_LAST_BANK 4'hf
`define CFP_BANK_BITS 4
`define CFP_SECOND_WORD_TAG 4'hf
`define CFP_PCL_ADDR 12'hff9
`define CFP_PC_HIGH_HOLDING_LATCH_ADDR 12'hffa
`define CFP_PC_UPPER_HOLDING_LATCH_ADDR 12'hffb
`define CFP_BSR_ADDR 12'hfe0
`define CFP_TABLE_LATCH_ADDR 12'hff5
`define CFP_TBLPTRL_ADDR 12'hff6
`define CFP_TBLPTRH_ADDR 12'hff7
`define CFP_TBLPTRU_ADDR 12'hff8
`define CFP_WORKING_REGISTER_ADDR 12'hfe8
`endif

// ---- hw/cfp_pkg.sv ----
// types shared by the fetch pipeline core
package cfp_pkg;
   typedef enum logic [1:0] {
      CFP_PH_ONE,
      CFP_PH_TWO,
      CFP_PH_THREE,
      CFP_PH_FOUR
   } cfp_phase_type;
   typedef enum logic [3:0] {
      CFP_OP_NOP,
      CFP_OP_GOTO,
      CFP_OP_CALL,
      CFP_OP_BRA,
      CFP_OP_MOVE_FILE_TO_FILE,
      CFP_OP_LOAD_INDIRECT_POINTER,
      CFP_OP_ADD_WORKING_TO_FILE,
      CFP_OP_MOVWF,
      CFP_OP_MOVLW,
      CFP_OP_TEST_SKIP_IF_ZERO,
      CFP_OP_MOVLB,
      CFP_OP_TBLRD,
      CFP_OP_TBLWT,
      CFP_OP_SECOND
   } cfp_op_type;
endpackage

// ---- hw/cfp_phase_gen.sv ----
// four-phase divider that turns the core clock into instruction phases
`timescale 1ns/1ps
`include "cfp_params.svh"
module cfp_phase_gen
   import cfp_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic rst, // async reset, active high
   output cfp_phase_type phase, // current phase
   output logic ph1, // phase one enable
   output logic ph2, // phase two enable
   output logic ph3, // phase three enable
   output logic ph4 // phase four enable
);
   cfp_phase_type phase_reg;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_reg <= CFP_PH_ONE;
      end else begin
         case (phase_reg)
            CFP_PH_ONE: phase_reg <= CFP_PH_TWO;
            CFP_PH_TWO: phase_reg <= CFP_PH_THREE;
            CFP_PH_THREE: phase_reg <= CFP_PH_FOUR;
            default: phase_reg <= CFP_PH_ONE;
         endcase
      end
   end
   assign phase = phase_reg;
   assign ph1 = (phase_reg == CFP_PH_ONE);
   assign ph2 = (phase_reg == CFP_PH_TWO);
   assign ph3 = (phase_reg == CFP_PH_THREE);
   assign ph4 = (phase_reg == CFP_PH_FOUR);
   property p_four_phases;
      @(posedge clk) disable iff (rst) ph1 |=> ph2 ##1 ph3 ##1 ph4 ##1 ph1;
   endproperty
   a_four_phases: assert property (p_four_phases) else $error("phase sequence broken");
   property p_phase_onehot;
      @(posedge clk) disable iff (rst) $onehot({ph1, ph2, ph3, ph4});
   endproperty
   a_phase_onehot: assert property (p_phase_onehot) else $error("phases overlap");
endmodule

// ---- hw/cfp_core.sv ----
// fetch/execute pipeline, program counter and banked data memory of the core
`timescale 1ns/1ps
`include "cfp_params.svh"
// Operation
// - clock divided into four phases
// - program counter advances in phase one
// - fetched word latched in phase four
// - fetch overlaps execute, one per cycle
// - pc change flushes fetched word, two cycles
// - decode and execute in phases two-four
// - operand read phase two, write four
// - byte addressed, pc steps two, lsb zero
// - absolute target loads pc bits 20:1
// - branch offset counts words, doubled
// - second words tagged ones, twelve bits data
// - lone second word executes as nop
// - table access one byte via latch
// - data memory twelve bit addressed
// - sixteen banks, low four selector bits
// - special registers top, general from bottom
// - unimplemented locations read zero
// - indirect pointer holds full address
// - file move two words, two cycles
// - access bank reachable regardless of bank
// - general registers never reset
// - pc low write loads pc from latches
module cfp_core
   import cfp_pkg::*;
#(
   parameter int GPR_BYTES = `CFP_GPR_BYTES
) (
   input wire logic CORE_CLK, // core clock
   input wire logic RST, // async reset, active high
   input wire logic [15:0] PROG_RDATA, // program memory word
   input wire logic [7:0] PROG_BYTE, // program memory byte for table access
   output logic [20:0] PROG_ADDR, // program fetch byte address
   output logic [20:0] TABLE_ADDR, // table access byte address
   output logic TABLE_RD, // table read strobe
   output logic TABLE_WR, // table write strobe
   output logic [7:0] TABLE_WDATA, // table write byte
   output logic [1:0] PHASE, // phase of the previous cycle, registered
   output logic [15:0] IR_OUT, // instruction register
   output logic FLUSH // pipeline flushed this cycle
);
   logic ph1, ph2, ph3, ph4;
   cfp_phase_type phase;
   cfp_phase_gen cfp_phase_gen_i (
      .clk(CORE_CLK),
      .rst(RST),
      .phase(phase),
      .ph1(ph1),
      .ph2(ph2),
      .ph3(ph3),
      .ph4(ph4)
   );
   logic [20:0] pc_reg, fetch_addr_reg;
   logic [15:0] fetch_reg, ir_reg;
   logic ir_valid_reg, fetch_valid_reg, second_pending_reg, skip_reg;
   logic [15:0] first_word_reg;
   logic [7:0] working_register_reg, bank_selector_reg, table_latch_reg;
   logic [7:0] pc_high_holding_latch_reg, pc_upper_holding_latch_reg;
   logic [20:0] table_pointer_reg;
   logic [11:0] indirect_pointer_reg;
   logic [7:0] operand_reg;
   logic [7:0] gpr_mem [0:GPR_BYTES-1];
   logic [11:0] src_addr, dst_addr;
   logic [7:0] rd_data, wr_data;
   logic wr_en, pc_load;
   logic [20:0] pc_target;
   cfp_op_type op;
   // decode the opcode groups; tagged words are second words
   always_comb begin
      op = CFP_OP_NOP;
      if (ir_reg[15:12] == `CFP_SECOND_WORD_TAG) op = CFP_OP_SECOND;
      else if (ir_reg[15:8] == 8'hef) op = CFP_OP_GOTO;
      else if (ir_reg[15:9] == 7'h76) op = CFP_OP_CALL;
      else if (ir_reg[15:11] == 5'h1a) op = CFP_OP_BRA;
      else if (ir_reg[15:12] == 4'hc) op = CFP_OP_MOVE_FILE_TO_FILE;
      else if (ir_reg[15:6] == 10'h3b8) op = CFP_OP_LOAD_INDIRECT_POINTER;
      else if (ir_reg[15:10] == 6'h09) op = CFP_OP_ADD_WORKING_TO_FILE;
      else if (ir_reg[15:9] == 7'h37) op = CFP_OP_MOVWF;
      else if (ir_reg[15:8] == 8'h0e) op = CFP_OP_MOVLW;
      else if (ir_reg[15:9] == 7'h33) op = CFP_OP_TEST_SKIP_IF_ZERO;
      else if (ir_reg[15:8] == 8'h01) op = CFP_OP_MOVLB;
      else if (ir_reg[15:0] == 16'h0008) op = CFP_OP_TBLRD;
      else if (ir_reg[15:0] == 16'h000c) op = CFP_OP_TBLWT;
   end
   // access bit clear selects the access bank, ignoring the selector
   function automatic logic [11:0] direct_addr(input logic [7:0] f, input logic a, input logic [7:0] bank_selector);
      logic [11:0] r;
      r = {bank_selector[3:0], f};
      // low half bank zero, high half special registers
      if (!a) r = (f < `CFP_ACCESS_SPLIT) ? {4'h0, f} : {`CFP_LAST_BANK, f};
      return r;
   endfunction
   // bank chosen by low selector bits
   always_comb begin
      src_addr = direct_addr(ir_reg[7:0], ir_reg[8], bank_selector_reg);
      if (op == CFP_OP_MOVE_FILE_TO_FILE) src_addr = ir_reg[11:0];
   end
   // second word of the file move carries the destination
   assign dst_addr = second_pending_reg ? ir_reg[11:0] : src_addr;
   // full 12-bit space, gpr bottom, sfr top
   function automatic logic [7:0] read_loc(input logic [11:0] a, input logic [7:0] g);
      logic [7:0] r;
      // special map at the top, gpr from zero
      r = 8'h00;
      if (a < 12'(GPR_BYTES)) r = g;
      else if (a == `CFP_WORKING_REGISTER_ADDR) r = working_register_reg;
      else if (a == `CFP_BSR_ADDR) r = {4'h0, bank_selector_reg[3:0]};
      else if (a == `CFP_PCL_ADDR) r = pc_reg[7:0];
      else if (a == `CFP_PC_HIGH_HOLDING_LATCH_ADDR) r = pc_high_holding_latch_reg;
      else if (a == `CFP_PC_UPPER_HOLDING_LATCH_ADDR) r = {3'h0, pc_upper_holding_latch_reg[4:0]};
      else if (a == `CFP_TABLE_LATCH_ADDR) r = table_latch_reg;
      else if (a == `CFP_TBLPTRL_ADDR) r = table_pointer_reg[7:0];
      else if (a == `CFP_TBLPTRH_ADDR) r = table_pointer_reg[15:8];
      else if (a == `CFP_TBLPTRU_ADDR) r = {3'h0, table_pointer_reg[20:16]};
      return r;
   endfunction
   assign rd_data = read_loc(src_addr, gpr_mem[src_addr[7:0]]);
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) operand_reg <= 8'h00;
      else if (ph2) operand_reg <= rd_data;
   end
   logic exec_ok;
   // lone second word and skipped words do nothing
   assign exec_ok = ir_valid_reg && !skip_reg;
   always_comb begin
      wr_en = 1'b0;
      wr_data = operand_reg;
      if (exec_ok && ph4) begin
         if (second_pending_reg) wr_en = 1'b1;
         else if (op == CFP_OP_ADD_WORKING_TO_FILE) begin
            wr_en = 1'b1;
            wr_data = operand_reg + working_register_reg;
         end else if (op == CFP_OP_MOVWF) begin
            wr_en = 1'b1;
            wr_data = working_register_reg;
         end
      end
   end
   always_ff @(posedge CORE_CLK) begin
      if (wr_en && dst_addr < 12'(GPR_BYTES)) gpr_mem[dst_addr[7:0]] <= wr_data;
   end
   // absolute targets land on pc bits 20:1
   always_comb begin
      pc_load = 1'b0;
      pc_target = pc_reg;
      if (exec_ok && ph4) begin
         if (second_pending_reg && (first_word_reg[15:8] == 8'hef || first_word_reg[15:9] == 7'h76)) begin
            pc_load = 1'b1;
            pc_target = {ir_reg[11:0], first_word_reg[7:0], 1'b0};
         end else if (!second_pending_reg && op == CFP_OP_BRA) begin
            pc_load = 1'b1;
            pc_target = 21'(pc_reg + {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0});
         end else if (wr_en && dst_addr == `CFP_PCL_ADDR) begin
            // pc low write pulls in holding latches
            pc_load = 1'b1;
            pc_target = {pc_upper_holding_latch_reg[4:0], pc_high_holding_latch_reg, wr_data[7:1], 1'b0};
         end
      end
   end
   // step of two, lsb held zero
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) pc_reg <= `CFP_PC_RESET;
      else if (pc_load) pc_reg <= {pc_target[20:1], 1'b0};
      else if (ph1) pc_reg <= pc_reg + `CFP_PC_STEP;
   end
   // fetched word latched in phase four
   // a pc change discards the word in flight
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         fetch_reg <= 16'h0000;
         fetch_addr_reg <= `CFP_PC_RESET;
         fetch_valid_reg <= 1'b0;
      end else if (ph1) begin
         fetch_addr_reg <= pc_reg;
      end else if (ph4) begin
         fetch_reg <= PROG_RDATA;
         fetch_valid_reg <= !pc_load;
      end
   end
   // execute stage loads while next word is fetched
   // decode and execute span phases two to four
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ir_reg <= 16'h0000;
         ir_valid_reg <= 1'b0;
         second_pending_reg <= 1'b0;
         skip_reg <= 1'b0;
         first_word_reg <= 16'h0000;
      end else if (ph4) begin
         ir_reg <= PROG_RDATA;
         // the word latched while the pc is reloaded is dropped
         ir_valid_reg <= !pc_load;
         second_pending_reg <= exec_ok && !second_pending_reg &&
            (op == CFP_OP_GOTO || op == CFP_OP_CALL || op == CFP_OP_MOVE_FILE_TO_FILE || op == CFP_OP_LOAD_INDIRECT_POINTER);
         skip_reg <= exec_ok && !second_pending_reg && op == CFP_OP_TEST_SKIP_IF_ZERO && operand_reg != 8'h00;
         first_word_reg <= ir_reg;
      end
   end
   // indirect pointer loaded with full address
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) indirect_pointer_reg <= 12'h000;
      else if (exec_ok && ph4 && second_pending_reg && first_word_reg[15:6] == 10'h3b8)
         indirect_pointer_reg <= {first_word_reg[3:0], ir_reg[7:0]};
   end
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         working_register_reg <= 8'h00;
         bank_selector_reg <= 8'h00;
         pc_high_holding_latch_reg <= 8'h00;
         pc_upper_holding_latch_reg <= 8'h00;
      end else if (exec_ok && ph4 && !second_pending_reg) begin
         if (op == CFP_OP_MOVLW) working_register_reg <= ir_reg[7:0];
         if (op == CFP_OP_MOVLB) bank_selector_reg <= {4'h0, ir_reg[3:0]};
         if (wr_en && dst_addr == `CFP_BSR_ADDR) bank_selector_reg <= {4'h0, wr_data[3:0]};
         if (wr_en && dst_addr == `CFP_PC_HIGH_HOLDING_LATCH_ADDR) pc_high_holding_latch_reg <= wr_data;
         if (wr_en && dst_addr == `CFP_PC_UPPER_HOLDING_LATCH_ADDR) pc_upper_holding_latch_reg <= {3'h0, wr_data[4:0]};
      end
   end
   // one byte per table operation through the latch
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         table_latch_reg <= 8'h00;
         table_pointer_reg <= 21'h000000;
         TABLE_RD <= 1'b0;
         TABLE_WR <= 1'b0;
      end else begin
         TABLE_RD <= exec_ok && ph3 && !second_pending_reg && op == CFP_OP_TBLRD;
         TABLE_WR <= exec_ok && ph3 && !second_pending_reg && op == CFP_OP_TBLWT;
         if (TABLE_RD) table_latch_reg <= PROG_BYTE;
         if (wr_en && dst_addr == `CFP_TABLE_LATCH_ADDR) table_latch_reg <= wr_data;
         if (wr_en && dst_addr == `CFP_TBLPTRL_ADDR) table_pointer_reg[7:0] <= wr_data;
         if (wr_en && dst_addr == `CFP_TBLPTRH_ADDR) table_pointer_reg[15:8] <= wr_data;
         if (wr_en && dst_addr == `CFP_TBLPTRU_ADDR) table_pointer_reg[20:16] <= wr_data[4:0];
      end
   end
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         PROG_ADDR <= `CFP_PC_RESET;
         TABLE_ADDR <= 21'h000000;
         TABLE_WDATA <= 8'h00;
         PHASE <= 2'h0;
         IR_OUT <= 16'h0000;
         FLUSH <= 1'b0;
      end else begin
         // fetch address is the pc before its phase-one step
         if (ph1) PROG_ADDR <= pc_reg;
         TABLE_ADDR <= table_pointer_reg;
         TABLE_WDATA <= table_latch_reg;
         PHASE <= phase;
         IR_OUT <= ir_reg;
         FLUSH <= pc_load;
      end
   end
   property p_pc_even;
      @(posedge CORE_CLK) disable iff (RST) pc_reg[0] == 1'b0;
   endproperty
   a_pc_even: assert property (p_pc_even) else $error("pc lsb not zero");
   property p_flush_out;
      @(posedge CORE_CLK) disable iff (RST) pc_load |=> FLUSH;
   endproperty
   a_flush_out: assert property (p_flush_out) else $error("flush not reported");
   property p_table_pulse;
      @(posedge CORE_CLK) disable iff (RST) TABLE_RD |=> !TABLE_RD;
   endproperty
   a_table_pulse: assert property (p_table_pulse) else $error("table read longer than one cycle");
   sequence s_load_cycle;
      pc_load ##1 ph1;
   endsequence
   property p_fetch_target;
      @(posedge CORE_CLK) disable iff (RST) s_load_cycle |=> PROG_ADDR == $past(pc_reg);
   endproperty
   a_fetch_target: assert property (p_fetch_target) else $error("new target not fetched");
   property p_pc_step;
      @(posedge CORE_CLK) disable iff (RST) (ph1 && !pc_load) |=> pc_reg == 21'($past(pc_reg) + 21'h2);
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step by two");
   property p_flush;
      @(posedge CORE_CLK) disable iff (RST) pc_load |=> !ir_valid_reg;
   endproperty
   a_flush: assert property (p_flush) else $error("word after pc change not flushed");
   property p_write_phase;
      @(posedge CORE_CLK) disable iff (RST) wr_en |-> ph4;
   endproperty
   a_write_phase: assert property (p_write_phase) else $error("write outside phase four");
   property p_bank;
      @(posedge CORE_CLK) disable iff (RST) bank_selector_reg[7:4] == 4'h0;
   endproperty
   a_bank: assert property (p_bank) else $error("selector upper bits set");
   property p_lone_second;
      @(posedge CORE_CLK) disable iff (RST) (op == CFP_OP_SECOND && !second_pending_reg) |-> !wr_en && !pc_load;
   endproperty
   a_lone_second: assert property (p_lone_second) else $error("lone second word acted");
   property p_zero_read;
      @(posedge CORE_CLK) disable iff (RST) (src_addr >= 12'(GPR_BYTES) && src_addr < `CFP_SFR_BASE) |-> rd_data == 8'h00;
   endproperty
   a_zero_read: assert property (p_zero_read) else $error("unimplemented read nonzero");
   property p_ir_load;
      @(posedge CORE_CLK) disable iff (RST) ph4 |=> ir_reg == $past(PROG_RDATA);
   endproperty
   a_ir_load: assert property (p_ir_load) else $error("ir not loaded at phase four");
endmodule

// ---- tb/cfp_prog_mem.sv ----
// program memory model answering fetches and table byte reads
`timescale 1ns/1ps
module cfp_prog_mem (
   input wire logic [20:0] addr, // fetch byte address
   input wire logic [20:0] table_addr, // table byte address
   output logic [15:0] rdata, // word at fetch address
   output logic [7:0] rbyte // byte at table address
);
   // small array, upper address bits alias onto it
   logic [15:0] mem [0:511];
   logic [15:0] tword;
   // words sit on even byte addresses
   assign rdata = mem[addr[9:1]];
   assign tword = mem[table_addr[9:1]];
   // one byte, low byte at even
   assign rbyte = table_addr[0] ? tword[15:8] : tword[7:0];
endmodule

// ---- tb/test_cfp_core.sv ----
// self-checking bench for the fetch pipeline core
`timescale 1ns/1ps
module test_cfp_core;
   logic core_clk;
   logic rst;
   logic [15:0] prog_rdata;
   logic [7:0] prog_byte;
   logic [20:0] prog_addr;
   logic [20:0] table_addr;
   logic table_rd;
   logic [7:0] table_wdata;
   logic [1:0] phase;
   logic [15:0] ir_out;
   logic flush;
   int err_count = 0;
   int checks = 0;

   cfp_core #(.GPR_BYTES(256)) cfp_core_i (
      .CORE_CLK(core_clk), .RST(rst), .PROG_RDATA(prog_rdata), .PROG_BYTE(prog_byte),
      .PROG_ADDR(prog_addr), .TABLE_ADDR(table_addr), .TABLE_RD(table_rd), .TABLE_WR(),
      .TABLE_WDATA(table_wdata), .PHASE(phase), .IR_OUT(ir_out), .FLUSH(flush));
   cfp_prog_mem cfp_prog_mem_i (
      .addr(prog_addr), .table_addr(table_addr), .rdata(prog_rdata), .rbyte(prog_byte));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic stop_test();
      if (err_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk_addr(input logic [20:0] got, input logic [20:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      chk_addr({5'h00, got}, {5'h00, exp});
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_addr({20'h00000, got}, {20'h00000, exp});
   endtask

   // every word defaults to a harmless literal load
   task automatic fill();
      for (int i = 0; i < 512; i++) begin
         cfp_prog_mem_i.mem[i] = {8'h0e, i[7:0]};
      end
   endtask

   task automatic restart();
      rst = 1'b1;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
   endtask

   task automatic wait_phase(input logic [1:0] p);
      int n;
      n = 0;
      @(negedge core_clk);
      while (phase !== p && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      chk_word({14'h0000, phase}, {14'h0000, p});
   endtask

   task automatic wait_addr(input logic [20:0] target, input int bound, output logic hit, output logic fl);
      hit = 1'b0;
      fl = 1'b0;
      for (int i = 0; i < bound && !hit; i++) begin
         @(negedge core_clk);
         if (flush === 1'b1) fl = 1'b1;
         if (prog_addr === target) hit = 1'b1;
      end
   endtask

   task automatic t_phases();
      logic [1:0] prev;
      fill();
      restart();
      @(negedge core_clk);
      prev = phase;
      for (int i = 0; i < 12; i++) begin
         @(negedge core_clk);
         chk_word({14'h0000, phase}, {14'h0000, prev + 2'd1});
         prev = phase;
      end
   endtask

   // sampled in phase four (PHASE reads 2, phase three): ir holds the word fetched one cycle earlier
   task automatic t_sequential();
      logic [20:0] prev;
      fill();
      restart();
      wait_phase(2'd2);
      prev = prog_addr;
      for (int i = 0; i < 6; i++) begin
         wait_phase(2'd2);
         chk_addr(prog_addr, prev + 21'h000002);
         chk_bit(prog_addr[0], 1'b0);
         chk_word(ir_out, cfp_prog_mem_i.mem[prev[9:1]]);
         prev = prog_addr;
      end
   endtask

   task automatic t_goto();
      logic hit;
      logic fl;
      fill();
      cfp_prog_mem_i.mem[4] = 16'hef20;
      cfp_prog_mem_i.mem[5] = 16'hf000;
      cfp_prog_mem_i.mem[32] = 16'h0e77;
      restart();
      wait_addr(21'h000040, 80, hit, fl);
      chk_bit(hit, 1'b1);
      chk_bit(fl, 1'b1);
      wait_addr(21'h000042, 12, hit, fl);
      wait_phase(2'd2);
      chk_word(ir_out, 16'h0e77);
   endtask

   // nonzero test skips the first word, its tagged second word must not jump
   task automatic t_skip();
      logic hit;
      logic fl;
      fill();
      cfp_prog_mem_i.mem[0] = 16'h0e05;
      cfp_prog_mem_i.mem[1] = 16'h66e8;
      cfp_prog_mem_i.mem[2] = 16'hef20;
      cfp_prog_mem_i.mem[3] = 16'hf000;
      restart();
      wait_addr(21'h00000c, 60, hit, fl);
      chk_bit(hit, 1'b1);
   endtask

   task automatic t_table();
      logic [20:0] seen;
      seen = 21'h1fffff;
      fill();
      cfp_prog_mem_i.mem[0] = 16'h0e34;
      cfp_prog_mem_i.mem[1] = 16'h6ef6;
      cfp_prog_mem_i.mem[2] = 16'h0008;
      cfp_prog_mem_i.mem[26] = 16'hc3a5;
      restart();
      for (int i = 0; i < 60; i++) begin
         @(negedge core_clk);
         if (table_rd === 1'b1) seen = table_addr;
      end
      chk_addr(seen, 21'h000034);
      chk_word({8'h00, table_wdata}, 16'h00a5);
   endtask

   task automatic t_computed();
      logic hit;
      hit = 1'b0;
      fill();
      cfp_prog_mem_i.mem[0] = 16'h0e01;
      cfp_prog_mem_i.mem[1] = 16'h6efa;
      // even byte offset keeps the target aligned
      cfp_prog_mem_i.mem[2] = 16'h0e10;
      cfp_prog_mem_i.mem[3] = 16'h26f9;
      restart();
      for (int i = 0; i < 80; i++) begin
         @(negedge core_clk);
         if (prog_addr[20:8] === 13'h0001 && prog_addr[0] === 1'b0) hit = 1'b1;
      end
      chk_bit(hit, 1'b1);
   endtask

   // whole run is a few hundred cycles, so this limit only trips on a hang
   initial begin
      repeat (3000) @(posedge core_clk);
      err_count++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      t_phases();
      t_sequential();
      t_goto();
      t_skip();
      t_table();
      t_computed();
      stop_test();
   end
endmodule
